/* File: rtl/sarc_defines.vh */
`ifndef SARC_DEFINES_VH
`define SARC_DEFINES_VH

// Alarm cause bit positions
`define SARC_SRC_PHYS      0
`define SARC_SRC_OPCODE    1
`define SARC_SRC_HSHAKE    2
`define SARC_SRC_INTEG     3
`define SARC_SRC_MISMATCH  4
`define SARC_SRC_WDOG      5
`define SARC_SRC_CHKPT     6
`define SARC_NUM_SRC       7

// Reset values
`define SARC_KEY_RST       32'h0000_0000
`define SARC_CAUSE_RST     7'h00

// Timing counts in cycles
`define SARC_HS_TIMEOUT    8'h10
`define SARC_WDOG_RELOAD   16'hFFFF

`endif

/* File: rtl/sarc_key_mem.v */
`timescale 1ns/1ps
`default_nettype none
module sarc_key_mem #(
    parameter DW = 32,
    parameter AW = 3
) (
    // Clock
    input  wire          i_clk,
    // Access
    input  wire          i_we,
    input  wire [AW-1:0] i_addr,
    input  wire [DW-1:0] i_wdata,
    output reg  [DW-1:0] o_rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end
endmodule // sarc_key_mem
`default_nettype wire

/* File: rtl/sarc_alarm_ctrl.v */
// Summary of operation
// [RULE_01] Physical probe or manipulation alarm halts processing and enters security reset.
// [RULE_02] On reset release, coprocessor registers and memory return to reset values.
// [RULE_03] During security reset all stored keys are overwritten with defaults.
// [RULE_04] During security reset memory structures are filled from the random source.
// [RULE_05] Illegal opcode detection triggers a security reset.
// [RULE_06] Bus transfers use a monitored handshake; failures raise an alarm.
// [RULE_07] Both processor halves compute on same data; final results are compared.
// [RULE_08] Result mismatch is recorded and starts the internal reset process.
// [RULE_09] Security critical integrity errors raise alarm and enter secure state.
// [RULE_10] Coprocessor soft reset or key overwrite clears all its key registers.
// [RULE_11] Watchdog timer and checkpoint register check timing and program flow.
// [RULE_12] Self-test, after start-up, exercises every alarm source and feature; code only waits until software has raised all 7 sources.
// [RULE_13] Cause of last security reset is latched and readable afterwards.
`timescale 1ns/1ps
`default_nettype none
`include "sarc_defines.vh"
module sarc_alarm_ctrl #(
    parameter DW       = 32,
    parameter MEM_AW   = 3,
    parameter KEY_N    = 4
) (
    // Clock and reset
    input  wire              i_clk,
    input  wire              i_sys_rst,
    // Detector pins (asynchronous)
    input  wire              i_phys_alarm,
    input  wire              i_integ_crit_alarm,
    // Core status, same clock
    input  wire              i_illegal_opcode,
    input  wire              i_res_valid,
    input  wire [DW-1:0]     i_res_a,
    input  wire [DW-1:0]     i_res_b,
    // Bus handshake monitor
    input  wire              i_bus_req,
    input  wire              i_bus_ack,
    input  wire              i_hs_alarm_en,
    // Random source
    input  wire [DW-1:0]     i_rand,
    // Coprocessor key control
    input  wire              i_cop_soft_rst,
    input  wire              i_key_we,
    input  wire [1:0]        i_key_sel,
    input  wire [DW-1:0]     i_key_wdata,
    // Watchdog and checkpoint
    input  wire              i_wdog_kick,
    input  wire              i_chkpt_we,
    input  wire [DW-1:0]     i_chkpt_wdata,
    input  wire [DW-1:0]     i_chkpt_expect,
    // Self-test
    input  wire              i_startup_done,
    input  wire              i_selftest_start,
    // Memory port
    input  wire [MEM_AW-1:0] i_mem_addr,
    output reg  [DW-1:0]     o_mem_rdata,
    // Status
    output reg               o_halt,
    output reg               o_sec_rst,
    output reg               o_cop_rst,
    output reg  [`SARC_NUM_SRC-1:0] o_rst_cause,
    output reg  [DW*KEY_N-1:0] o_keys,
    output reg               o_selftest_busy,
    output reg               o_selftest_pass
);
    localparam NS = `SARC_NUM_SRC;
    localparam [2:0] ST_RUN  = 3'b001;
    localparam [2:0] ST_WIPE = 3'b010;
    localparam [2:0] ST_REL  = 3'b100;

    reg [1:0]  phys_sync_q;
    reg [1:0]  integ_sync_q;
    reg [2:0]  state_q;
    reg [MEM_AW-1:0] wipe_addr_q;
    reg [7:0]  hs_cnt_q;
    reg [15:0] wdog_q;
    reg [NS-1:0] test_inj_q;
    reg [NS-1:0] test_seen_q;
    reg [NS-1:0] alarm;
    reg [NS-1:0] raw;
    wire [DW-1:0] mem_rdata;
    wire mem_we;
    wire [MEM_AW-1:0] mem_addr;
    integer k;

    // Pins pass two flops first
    always @(posedge i_clk) begin
        phys_sync_q  <= {phys_sync_q[0], i_phys_alarm};
        integ_sync_q <= {integ_sync_q[0], i_integ_crit_alarm};
    end

    always @* begin
        raw = {NS{1'b0}};
        // [RULE_01] probe alarm source
        raw[`SARC_SRC_PHYS]     = phys_sync_q[1];
        // [RULE_05] illegal opcode source
        raw[`SARC_SRC_OPCODE]   = i_illegal_opcode;
        // [RULE_06] failed handshake, gated
        raw[`SARC_SRC_HSHAKE]   = i_hs_alarm_en && (hs_cnt_q == `SARC_HS_TIMEOUT);
        // [RULE_09] critical integrity error
        raw[`SARC_SRC_INTEG]    = integ_sync_q[1];
        // [RULE_07] compare both halves
        raw[`SARC_SRC_MISMATCH] = i_res_valid && (i_res_a != i_res_b);
        // [RULE_11] watchdog expiry
        raw[`SARC_SRC_WDOG]     = (wdog_q == 16'h0000);
        // [RULE_11] program flow checkpoint
        raw[`SARC_SRC_CHKPT]    = i_chkpt_we && (i_chkpt_wdata != i_chkpt_expect);
        // Self-test injection diverts alarms away from reset
        alarm = raw & ~test_inj_q;
    end

    // [RULE_06] handshake timeout counter
    always @(posedge i_clk) begin
        if (i_sys_rst || !i_bus_req || i_bus_ack) begin
            hs_cnt_q <= 8'h00;
        end else if (hs_cnt_q != `SARC_HS_TIMEOUT) begin
            hs_cnt_q <= hs_cnt_q + 8'h01;
        end
    end

    // [RULE_11] watchdog down counter
    always @(posedge i_clk) begin
        if (i_sys_rst || i_wdog_kick || state_q != ST_RUN) begin
            wdog_q <= `SARC_WDOG_RELOAD;
        end else if (wdog_q != 16'h0000) begin
            wdog_q <= wdog_q - 16'h0001;
        end
    end

    // Security reset sequencer
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_q     <= ST_RUN;
            wipe_addr_q <= {MEM_AW{1'b0}};
            o_halt      <= 1'b0;
            o_sec_rst   <= 1'b0;
            o_cop_rst   <= 1'b0;
            o_rst_cause <= `SARC_CAUSE_RST;
        end else begin
            o_cop_rst <= 1'b0;
            case (state_q)
                ST_RUN: begin
                    if (|alarm) begin
                        // [RULE_01] halt at once
                        o_halt      <= 1'b1;
                        o_sec_rst   <= 1'b1;
                        // [RULE_13] latch cause
                        o_rst_cause <= alarm;
                        // [RULE_08] mismatch starts reset
                        state_q     <= ST_WIPE;
                        wipe_addr_q <= {MEM_AW{1'b0}};
                    end
                end
                ST_WIPE: begin
                    // [RULE_04] walk memory with random fill
                    wipe_addr_q <= wipe_addr_q + {{(MEM_AW-1){1'b0}}, 1'b1};
                    if (&wipe_addr_q) begin
                        state_q <= ST_REL;
                    end
                end
                ST_REL: begin
                    // [RULE_02] coprocessor reset on release
                    o_cop_rst <= 1'b1;
                    o_sec_rst <= 1'b0;
                    o_halt    <= 1'b0;
                    state_q   <= ST_RUN;
                end
                default: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end

    // Key registers
    always @(posedge i_clk) begin
        if (i_sys_rst || state_q != ST_RUN || i_cop_soft_rst) begin
            // [RULE_03] [RULE_10] keys to defaults
            for (k = 0; k < KEY_N; k = k + 1) begin
                o_keys[k*DW +: DW] <= `SARC_KEY_RST;
            end
        end else if (i_key_we) begin
            // [RULE_10] overwrite clears all other keys
            for (k = 0; k < KEY_N; k = k + 1) begin
                o_keys[k*DW +: DW] <= `SARC_KEY_RST;
            end
            o_keys[i_key_sel*DW +: DW] <= i_key_wdata;
        end
    end

    assign mem_we   = (state_q == ST_WIPE);
    assign mem_addr = mem_we ? wipe_addr_q : i_mem_addr;

    sarc_key_mem #(
        .DW (DW),
        .AW (MEM_AW)
    ) u_mem (
        .i_clk   (i_clk),
        .i_we    (mem_we),
        .i_addr  (mem_addr),
        .i_wdata (i_rand),
        .o_rdata (mem_rdata)
    );

    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_mem_rdata <= {DW{1'b0}};
        end else begin
            o_mem_rdata <= (state_q == ST_RUN) ? mem_rdata : {DW{1'b0}};
        end
    end

    // [RULE_12] self-test, only after start-up
    // Limitation: tested sources must be stimulated by software
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            test_inj_q      <= {NS{1'b0}};
            test_seen_q     <= {NS{1'b0}};
            o_selftest_busy <= 1'b0;
            o_selftest_pass <= 1'b0;
        end else if (i_selftest_start && i_startup_done && !o_selftest_busy) begin
            test_inj_q      <= {NS{1'b1}};
            test_seen_q     <= {NS{1'b0}};
            o_selftest_busy <= 1'b1;
            o_selftest_pass <= 1'b0;
        end else if (o_selftest_busy) begin
            test_seen_q <= test_seen_q | raw;
            if (&(test_seen_q | raw)) begin
                test_inj_q      <= {NS{1'b0}};
                o_selftest_busy <= 1'b0;
                o_selftest_pass <= 1'b1;
            end
        end
    end
endmodule // sarc_alarm_ctrl
`default_nettype wire

/* File: bench/sarc_props.sv */
`timescale 1ns/1ps
`default_nettype none
module sarc_props #(
    parameter int DW    = 32,
    parameter int KEY_N = 4
) (
    // Clock, reset and requests
    input wire logic                i_clk,
    input wire logic                i_sys_rst,
    input wire logic                i_illegal_opcode,
    input wire logic                i_res_valid,
    input wire logic [DW-1:0]       i_res_a,
    input wire logic [DW-1:0]       i_res_b,
    input wire logic                i_cop_soft_rst,
    input wire logic                i_key_we,
    // Status
    input wire logic                o_halt,
    input wire logic                o_cop_rst,
    input wire logic [6:0]          o_rst_cause,
    input wire logic [DW*KEY_N-1:0] o_keys,
    input wire logic                o_selftest_busy
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // Alarms only count outside wipe, release and self-test
    wire run = !o_halt && !o_cop_rst && !o_selftest_busy;
    property p_opc; i_illegal_opcode && run |=> o_halt && o_rst_cause[1]; endproperty
    a_opc: assert property (p_opc) else $error("opcode alarm missed");
    property p_mis; i_res_valid && (i_res_a != i_res_b) && run |=> o_halt && o_rst_cause[4]; endproperty
    a_mis: assert property (p_mis) else $error("mismatch alarm missed");
    // Halt stands eight wipe cycles plus the release cycle
    property p_len;
        $rose(o_halt) |-> o_halt[*8] ##1 o_halt ##1 (!o_halt && o_cop_rst) ##1 !o_cop_rst;
    endproperty
    a_len: assert property (p_len) else $error("halt span wrong");
    property p_cop; $rose(o_cop_rst) |-> $past(o_halt) && !o_halt; endproperty
    a_cop: assert property (p_cop) else $error("coprocessor reset misplaced");
    property p_soft; i_cop_soft_rst && !i_key_we |=> o_keys == '0; endproperty
    a_soft: assert property (p_soft) else $error("soft reset left keys");
    property p_wipe; $rose(o_cop_rst) |-> o_keys == '0; endproperty
    a_wipe: assert property (p_wipe) else $error("keys survived wipe");
    property p_cause; !$rose(o_halt) |-> $stable(o_rst_cause); endproperty
    a_cause: assert property (p_cause) else $error("cause changed");
    property p_st; $past(o_selftest_busy) |-> !$rose(o_halt); endproperty
    a_st: assert property (p_st) else $error("reset during self-test");
    c_halt: cover property ($rose(o_halt));
    c_rel: cover property ($rose(o_cop_rst));
    c_st: cover property ($rose(o_selftest_busy));
endmodule // sarc_props
bind sarc_alarm_ctrl sarc_props #(.DW(DW), .KEY_N(KEY_N)) u_sarc_props (.i_clk, .i_sys_rst,
    .i_illegal_opcode, .i_res_valid, .i_res_a, .i_res_b, .i_cop_soft_rst, .i_key_we,
    .o_halt, .o_cop_rst, .o_rst_cause, .o_keys, .o_selftest_busy);
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic i_clk = 0, i_sys_rst = 1, i_phys_alarm = 0, i_integ_crit_alarm = 0;
    logic i_illegal_opcode = 0, i_res_valid = 0, i_bus_req = 0, i_bus_ack = 0;
    logic i_hs_alarm_en = 0, i_cop_soft_rst = 0, i_key_we = 0, i_wdog_kick = 0;
    logic i_chkpt_we = 0, i_startup_done = 0, i_selftest_start = 0;
    logic [31:0] i_res_a = 5, i_res_b = 6, i_rand = 1, i_key_wdata = 0;
    logic [31:0] i_chkpt_wdata = 1, i_chkpt_expect = 2, o_mem_rdata, w0, w_prev = 0;
    logic [1:0] i_key_sel = 0;
    logic [2:0] i_mem_addr = 0;
    logic o_halt, o_sec_rst, o_cop_rst, o_selftest_busy, o_selftest_pass;
    logic [6:0] o_rst_cause;
    logic [127:0] o_keys;
    int n_errors = 0, cmp_count = 0, k;
    sarc_alarm_ctrl u_sarc_alarm_ctrl (.i_clk, .i_sys_rst, .i_phys_alarm, .i_integ_crit_alarm,
        .i_illegal_opcode, .i_res_valid, .i_res_a, .i_res_b, .i_bus_req, .i_bus_ack,
        .i_hs_alarm_en, .i_rand, .i_cop_soft_rst, .i_key_we, .i_key_sel, .i_key_wdata,
        .i_wdog_kick, .i_chkpt_we, .i_chkpt_wdata, .i_chkpt_expect, .i_startup_done,
        .i_selftest_start, .i_mem_addr, .o_mem_rdata, .o_halt, .o_sec_rst, .o_cop_rst,
        .o_rst_cause, .o_keys, .o_selftest_busy, .o_selftest_pass);
    initial forever #20 i_clk = ~i_clk;
    // Odd step keeps the random words distinct
    always @(negedge i_clk) i_rand <= i_rand + 32'h3C6E_F35F;
    task automatic chk(input logic [127:0] g, e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic t_alarm(input int s);
        i_key_we = 1;
        i_key_sel = 2'h1;
        i_key_wdata = 32'hA5A5_0000 + s;
        cyc(1);
        i_key_we = 0;
        chk(o_keys, {64'h0, i_key_wdata, 32'h0});
        case (s)
            0: i_phys_alarm = 1;
            1: i_illegal_opcode = 1;
            2: i_bus_req = 1;
            3: i_integ_crit_alarm = 1;
            4: i_res_valid = 1;
            default: i_chkpt_we = 1;
        endcase
        for (k = 0; !o_halt && k < 40; k++) cyc(1);
        {i_phys_alarm, i_illegal_opcode, i_bus_req, i_integ_crit_alarm, i_res_valid} = 5'h00;
        i_chkpt_we = 0;
        chk(o_rst_cause, 128'h1 << (s == 5 ? 6 : s));
        chk(o_sec_rst, 128'h1);
        // Eight wipe cycles plus the release cycle
        for (k = 0; !o_cop_rst && k < 40; k++) cyc(1);
        chk(k, 128'h9);
        chk(o_sec_rst, 128'h0);
        chk(o_keys, 128'h0);
        cyc(1);
        chk(o_cop_rst, 128'h0);
        i_mem_addr = 3'h0;
        cyc(2);
        w0 = o_mem_rdata;
        i_mem_addr = 3'h1;
        cyc(2);
        // Word 0 must also differ from the previous wipe
        chk(w0 !== 32'h0 && w0 !== w_prev && o_mem_rdata !== w0, 128'h1);
        w_prev = w0;
        $display("alarm test %0d done", s);
    endtask
    task automatic t_quiet;
        {i_res_b, i_chkpt_wdata} = {32'h5, 32'h2};
        {i_res_valid, i_bus_req, i_chkpt_we} = 3'h7;
        cyc(3);
        i_bus_ack = 1;
        cyc(1);
        {i_res_valid, i_bus_req, i_chkpt_we, i_bus_ack} = 4'h0;
        {i_res_b, i_chkpt_wdata} = {32'h6, 32'h1};
        cyc(24);
        chk(o_halt, 128'h0);
        $display("quiet test done");
    endtask
    task automatic t_soft;
        i_key_we = 1;
        i_key_sel = 2'h0;
        i_key_wdata = 32'h0BAD_CAFE;
        cyc(1);
        chk(o_keys, {96'h0, 32'h0BAD_CAFE});
        i_key_sel = 2'h3;
        i_key_wdata = 32'h1234_5678;
        cyc(1);
        i_key_we = 0;
        i_cop_soft_rst = 1;
        chk(o_keys, {32'h1234_5678, 96'h0});
        cyc(1);
        i_cop_soft_rst = 0;
        chk(o_keys, 128'h0);
        $display("soft reset test done");
    endtask
    task automatic t_selftest;
        i_selftest_start = 1;
        cyc(1);
        chk(o_selftest_busy, 128'h0);
        i_startup_done = 1;
        // Watchdog left to run out as the last source seen
        i_wdog_kick = 0;
        cyc(1);
        i_selftest_start = 0;
        chk(o_selftest_busy, 128'h1);
        {i_phys_alarm, i_illegal_opcode, i_bus_req, i_integ_crit_alarm, i_res_valid} = 5'h1F;
        i_chkpt_we = 1;
        cyc(20);
        {i_phys_alarm, i_illegal_opcode, i_bus_req, i_integ_crit_alarm, i_res_valid} = 5'h00;
        i_chkpt_we = 0;
        cyc(4);
        chk(o_halt, 128'h0);
        chk(o_selftest_pass, 128'h0);
        for (k = 0; o_selftest_busy && k < 70000; k++) cyc(1);
        chk(o_selftest_pass, 128'h1);
        // Expired watchdog alarms once the diversion ends
        i_wdog_kick = 1;
        cyc(1);
        chk(o_halt, 128'h1);
        chk(o_rst_cause, 128'h20);
        $display("self-test test done");
    endtask
    task automatic tally_and_finish;
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        // Self-test alone waits out the 65535-cycle watchdog
        repeat (80000) @(posedge i_clk);
        n_errors++;
        tally_and_finish;
    end
    initial begin
        repeat (20) @(posedge i_clk);
        @(negedge i_clk);
        i_sys_rst = 0;
        // Kick held except while the self-test lets it run out
        i_wdog_kick = 1;
        i_hs_alarm_en = 1;
        t_quiet;
        for (int s = 0; s < 6; s++) t_alarm(s);
        t_soft;
        t_selftest;
        tally_and_finish;
    end
endmodule // tb_top
`default_nettype wire
